/* shared/sap_pkg.sv */
/*
 * Shared constants, types and helper functions of the serial audio port receiver.
 * Assumes nothing of its surroundings; the receiver and the bench import it whole.
 */
`default_nettype none
package sap_pkg;

    // ------------------------------------------------------------------
    // Word and slot geometry
    // ------------------------------------------------------------------
    localparam int WORD_W = 24;
    localparam int PAIR_W = 48;
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] WORD_MIN = 5'h10;
    localparam logic [4:0] WORD_MAX = 5'h18;
    localparam logic [5:0] SLOT_32FS = 6'h10;
    localparam logic [5:0] SLOT_48FS = 6'h18;
    localparam logic [5:0] SLOT_64FS = 6'h20;
    localparam logic [5:0] POS_MAX = 6'h3F;
    localparam logic [23:0] WORD_ONES = 24'hFFFFFF;

    // ------------------------------------------------------------------
    // Format codes and state types
    // ------------------------------------------------------------------
    localparam logic [1:0] FMT_I2S = 2'h0;
    localparam logic [1:0] FMT_LJ = 2'h1;
    localparam logic [1:0] FMT_RJ = 2'h2;

    typedef enum logic [1:0] {
        ST_WAIT_LEFT = 2'b01,
        ST_HAVE_LEFT = 2'b10
    } pair_state_t;

    // Configuration as seen by the link domain.
    typedef struct packed {
        logic sw;
        logic [1:0] fmt;
        logic [4:0] len;
    } link_cfg_t;

    // Levels brought into the system clock domain.
    typedef struct packed {
        logic pair_tog;
        logic bad_tog;
        logic sd_n;
        logic clip;
        logic fault_in;
        logic sw;
        logic ds_req;
        logic hpf_byp;
    } clk_sync_t;

    // Keeps the lowest n bits of a word and clears the rest.
    function automatic logic [23:0] keep_low(input logic [23:0] w, input logic [4:0] n);
        keep_low = w & ~(WORD_ONES << n);
    endfunction

    // Keeps the highest n bits of a word and clears the rest.
    function automatic logic [23:0] keep_high(input logic [23:0] w, input logic [4:0] n);
        keep_high = w & ~(WORD_ONES >> n);
    endfunction

    // Limits a requested word length to the accepted range.
    function automatic logic [4:0] clamp_len(input logic [4:0] n);
        clamp_len = (n < WORD_MIN) ? WORD_MIN : ((n > WORD_MAX) ? WORD_MAX : n);
    endfunction

    // True for a slot of 32, 48 or 64 bit clocks per frame.
    function automatic logic len_ok(input logic [5:0] p);
        len_ok = (p == SLOT_32FS) || (p == SLOT_48FS) || (p == SLOT_64FS);
    endfunction

endpackage
`default_nettype wire

/* shared/pair_stream_if.sv */
/*
 * Valid/ready stream of stereo sample pairs between the receiver and its FIFO.
 * Assumes both ends run on the same clock.
 */
`default_nettype none
interface pair_stream_if #(parameter int W = sap_pkg::PAIR_W);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

/* rtl/pair_fifo.sv */
/*
 * Synchronous FIFO for stereo sample pairs, width and depth as parameters.
 * Assumes one clock for both sides and a synchronous active-high reset.
 */
`default_nettype none
module pair_fifo #(
    parameter int W = 48,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset,
    pair_stream_if.sink wr,
    pair_stream_if.source rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic full;
    logic empty;

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    // An extra pointer bit tells a full ring from an empty one.
    assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty = (wp_q == rp_q);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem_q[rp_q[AW-1:0]];

    // Storage is written only when a word is accepted.
    always_ff @(posedge clk) begin
        if (wr.valid && !full) begin
            mem_q[wp_q[AW-1:0]] <= wr.data;
        end
    end

    // Pointers move on accepted pushes and pops.
    always_ff @(posedge clk) begin
        if (reset) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (wr.valid && !full) begin
                wp_q <= wp_q + 1'b1;
            end
            if (rd.ready && !empty) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end

    a_fifo_no_wrap: assert property (@(posedge clk) disable iff (reset)
        full && !(rd.ready && !empty) |=> full && $stable(wp_q))
        else $error("FIFO pointer moved while full");

endmodule
`default_nettype wire

/* rtl/serial_audio_port_receiver.sv */
/*
 * Stereo serial audio port receiver: I2S, left- and right-justified input at
 * 32, 48 or 64 bit clocks per frame, paired into stereo samples and buffered.
 * Assumes the source drives the channel select clock and serial data from the
 * falling edge of bit_clk, so both are stable at its rising edge.
 */
`default_nettype none
module serial_audio_port_receiver
    import sap_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic bit_clk,
    input wire logic channel_select_clock,
    input wire logic serial_data,
    input wire logic software_mode,
    input wire logic [1:0] format_sel,
    input wire logic [4:0] word_length,
    input wire logic double_speed_req,
    input wire logic hpf_bypass_req,
    input wire logic speaker_shutdown_pin_n,
    input wire logic soft_clip_pin,
    input wire logic fault_request,
    input wire logic speaker_fault_pin_in,
    output logic speaker_fault_pin_out,
    output logic speaker_fault_pin_oe,
    output logic speaker_enable,
    output logic soft_clip_enable,
    output logic fault_seen,
    output logic double_speed,
    output logic hpf_enable,
    output logic frame_error,
    output logic overrun,
    output logic pair_valid,
    input wire logic pair_ready,
    output logic [23:0] left_word,
    output logic [23:0] right_word
);

    // ------------------------------------------------------------------
    // Link domain: reset and configuration
    // ------------------------------------------------------------------
    logic lrst1_q;
    logic lrst_q;
    link_cfg_t cfg1_q;
    link_cfg_t cfg_q;
    logic [1:0] fmt;
    logic [4:0] wlen;

    // The system reset is brought onto the bit clock by two flops, so the
    // link logic leaves reset cleanly even though the clocks are unrelated.
    always_ff @(posedge bit_clk) begin
        lrst1_q <= reset;
        lrst_q <= lrst1_q;
    end

    // Configuration is static while audio runs, so a plain two-flop
    // synchroniser per bit is enough; changing it mid-stream may corrupt
    // one frame.
    always_ff @(posedge bit_clk) begin
        cfg1_q <= '{sw: software_mode, fmt: format_sel, len: word_length};
        cfg_q <= cfg1_q;
    end

    // bus mode selects a justified format
    always_comb begin
        fmt = FMT_I2S;
        if (cfg_q.sw && (cfg_q.fmt == FMT_LJ || cfg_q.fmt == FMT_RJ)) begin
            fmt = cfg_q.fmt;
        end
        wlen = cfg_q.sw ? clamp_len(cfg_q.len) : WORD_MAX;
    end

    // ------------------------------------------------------------------
    // Link domain: slot framing and capture
    // ------------------------------------------------------------------
    logic lr1_q;
    logic lr2_q;
    logic [5:0] pos_q;
    logic [23:0] w_q;
    logic [23:0] sr_q;
    logic chan_left_q;
    logic seen_q;
    logic boundary;
    logic new_left;
    logic [23:0] word_done;

    // select sampled on the rising edge
    // The select and data come from the link's own clock, so they are read
    // without a synchroniser.
    always_ff @(posedge bit_clk) begin
        if (lrst_q) begin
            // Track the live level so a high select at release is no false edge.
            lr1_q <= channel_select_clock;
            lr2_q <= channel_select_clock;
        end else begin
            lr1_q <= channel_select_clock;
            lr2_q <= lr1_q;
        end
    end

    // I2S slot starts one bit late
    // justified slot starts at the change
    always_comb begin
        if (fmt == FMT_I2S) begin
            boundary = lr1_q ^ lr2_q;
            new_left = !lr1_q;
        end else begin
            boundary = channel_select_clock ^ lr1_q;
            new_left = channel_select_clock;
        end
    end

    // right-justified word ends at slot end
    // leading bits of a short word cleared
    // a 24-bit word fills the last 24 bits
    assign word_done = (fmt == FMT_RJ) ? keep_low(sr_q, wlen) : w_q;

    // one bit shifted per bit clock
    // bits past the word length are cleared
    // The slot register is cleared at each boundary so a short slot leaves
    // zeros in every trailing position it never reached.
    always_ff @(posedge bit_clk) begin
        if (lrst_q) begin
            pos_q <= 6'h00;
            w_q <= 24'h000000;
            sr_q <= 24'h000000;
            chan_left_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            sr_q <= {sr_q[22:0], serial_data};
            if (boundary) begin
                pos_q <= 6'h01;
                w_q <= {serial_data, 23'h000000};
                chan_left_q <= new_left;
                seen_q <= 1'b1;
            end else begin
                if (pos_q != POS_MAX) begin
                    pos_q <= pos_q + 6'h01;
                end
                if (pos_q < 6'(WORD_W)) begin
                    w_q[5'(WORD_W - 1) - pos_q[4:0]] <= serial_data && (pos_q < {1'b0, wlen});
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Link domain: stereo pairing and frame check
    // ------------------------------------------------------------------
    pair_state_t st_q;
    logic [23:0] left_q;
    logic [23:0] xl_q;
    logic [23:0] xr_q;
    logic xtog_q;
    logic bad_tog_q;

    // left then right forms one pair
    // A right word without a left before it is dropped; the slot cut short
    // by reset is never used because seen_q is still low at its end.
    always_ff @(posedge bit_clk) begin
        if (lrst_q) begin
            st_q <= ST_WAIT_LEFT;
            left_q <= 24'h000000;
            xl_q <= 24'h000000;
            xr_q <= 24'h000000;
            xtog_q <= 1'b0;
        end else if (boundary && seen_q) begin
            case (st_q)
                ST_WAIT_LEFT: begin
                    if (chan_left_q) begin
                        left_q <= word_done;
                        st_q <= ST_HAVE_LEFT;
                    end
                end
                ST_HAVE_LEFT: begin
                    if (chan_left_q) begin
                        left_q <= word_done;
                    end else begin
                        xl_q <= left_q;
                        xr_q <= word_done;
                        xtog_q <= !xtog_q;
                        st_q <= ST_WAIT_LEFT;
                    end
                end
                default: begin
                    st_q <= ST_WAIT_LEFT;
                end
            endcase
        end
    end

    // slot length outside 32, 48, 64 per frame
    always_ff @(posedge bit_clk) begin
        if (lrst_q) begin
            bad_tog_q <= 1'b0;
        end else if (boundary && seen_q && !len_ok(pos_q)) begin
            bad_tog_q <= !bad_tog_q;
        end
    end

    // ------------------------------------------------------------------
    // System domain: synchronisers and pins
    // ------------------------------------------------------------------
    clk_sync_t s1_q;
    clk_sync_t s2_q;
    logic [1:0] t3_q;
    logic push;
    logic bad_pulse;

    // Toggles from the link and asynchronous pins pass two flops here.
    always_ff @(posedge clk) begin
        s1_q <= '{pair_tog: xtog_q, bad_tog: bad_tog_q, sd_n: speaker_shutdown_pin_n,
                  clip: soft_clip_pin, fault_in: speaker_fault_pin_in, sw: software_mode,
                  ds_req: double_speed_req, hpf_byp: hpf_bypass_req};
        s2_q <= s1_q;
    end

    // Third stage only for edge detection of the two toggles.
    always_ff @(posedge clk) begin
        if (reset) begin
            t3_q <= 2'b00;
        end else begin
            t3_q <= {s2_q.pair_tog, s2_q.bad_tog};
        end
    end

    assign push = s2_q.pair_tog ^ t3_q[1];
    assign bad_pulse = s2_q.bad_tog ^ t3_q[0];

    // pins stay live in both modes
    // double speed selectable in bus mode
    // filter bypass only in bus mode
    always_ff @(posedge clk) begin
        if (reset) begin
            speaker_enable <= 1'b0;
            soft_clip_enable <= 1'b0;
            fault_seen <= 1'b0;
            speaker_fault_pin_oe <= 1'b0;
            double_speed <= 1'b0;
            hpf_enable <= 1'b1;
        end else begin
            speaker_enable <= s2_q.sd_n;
            soft_clip_enable <= s2_q.clip;
            fault_seen <= !s2_q.fault_in;
            speaker_fault_pin_oe <= fault_request;
            double_speed <= s2_q.sw && s2_q.ds_req;
            hpf_enable <= !(s2_q.sw && s2_q.hpf_byp);
        end
    end

    // Open drain: the line is only ever pulled low.
    assign speaker_fault_pin_out = 1'b0;

    // ------------------------------------------------------------------
    // System domain: buffering and status
    // ------------------------------------------------------------------
    pair_stream_if #(.W(PAIR_W)) in_s ();
    pair_stream_if #(.W(PAIR_W)) out_s ();

    // The held pair is written a whole frame before the next update, so it is
    // stable when the synchronised toggle arrives here.
    assign in_s.valid = push;
    assign in_s.data = {xl_q, xr_q};
    assign out_s.ready = pair_ready;
    assign pair_valid = out_s.valid;
    assign left_word = out_s.data[47:24];
    assign right_word = out_s.data[23:0];

    pair_fifo #(.W(PAIR_W), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .wr(in_s),
        .rd(out_s)
    );

    // Audio cannot be stalled at the source, so a pair arriving at a full
    // FIFO is lost and the loss is held until reset.
    always_ff @(posedge clk) begin
        if (reset) begin
            overrun <= 1'b0;
            frame_error <= 1'b0;
        end else begin
            if (push && !in_s.ready) begin
                overrun <= 1'b1;
            end
            if (bad_pulse) begin
                frame_error <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_pin_mode_i2s: assert property (
        @(posedge bit_clk) disable iff (lrst_q) !cfg_q.sw |-> fmt == FMT_I2S && wlen == WORD_MAX)
        else $error("Pin mode left I2S format");

    a_i2s_left_low: assert property (
        @(posedge bit_clk) disable iff (lrst_q)
        fmt == FMT_I2S && boundary ##1 fmt == FMT_I2S |-> chan_left_q == !lr2_q)
        else $error("I2S channel assignment wrong");

    a_slot_first_bit: assert property (
        @(posedge bit_clk) disable iff (lrst_q)
        boundary |=> pos_q == 6'h01 && w_q[23] == $past(serial_data))
        else $error("Slot did not start with the current bit");

    a_lj_tail_zero: assert property (
        @(posedge bit_clk) disable iff (lrst_q)
        boundary && fmt == FMT_LJ |-> word_done == keep_high(word_done, wlen))
        else $error("Left-justified trailing bits not zero");

    a_rj_lead_zero: assert property (
        @(posedge bit_clk) disable iff (lrst_q)
        boundary && fmt == FMT_RJ |-> word_done == keep_low(word_done, wlen))
        else $error("Right-justified leading bits not zero");

    a_bad_slot_flag: assert property (
        @(posedge bit_clk) disable iff (lrst_q)
        boundary && seen_q && !len_ok(pos_q) |=> bad_tog_q != $past(bad_tog_q))
        else $error("Bad slot length not reported");

    a_pair_emit: assert property (
        @(posedge bit_clk) disable iff (lrst_q)
        boundary && seen_q && !chan_left_q && st_q == ST_HAVE_LEFT
        |=> xtog_q != $past(xtog_q) && xl_q == $past(left_q))
        else $error("Stereo pair not released");

    a_pair_to_fifo: assert property (
        @(posedge clk) disable iff (reset) push && in_s.ready |=> pair_valid)
        else $error("Accepted pair not visible");

    a_single_speed: assert property (
        @(posedge clk) disable iff (reset) !s2_q.sw |=> !double_speed)
        else $error("Double speed in pin mode");

    a_filter_forced: assert property (
        @(posedge clk) disable iff (reset) !s2_q.sw |=> hpf_enable)
        else $error("Filter bypassed in pin mode");

    a_fault_pulls_low: assert property (
        @(posedge clk) disable iff (reset)
        fault_request |=> speaker_fault_pin_oe && !speaker_fault_pin_out)
        else $error("Fault line not pulled low");

endmodule
`default_nettype wire

/* bench/audio_source.sv */
/*
 * Behavioural digital audio source driving the receiver's serial port.
 * Assumes the bench calls its tasks; the link clock stands low between calls.
 */
`default_nettype none
module audio_source (
    output logic bit_clk,
    output logic channel_select_clock,
    output logic serial_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Link clock and frames
    // ------------------------------------------------------------------

    // Lines start low and idle.
    initial begin
        bit_clk = 1'b0;
        channel_select_clock = 1'b0;
        serial_data = 1'b0;
    end

    // Runs the link clock with lines held, so the reset reaches the link side.
    task automatic idle(input int n);
        repeat (n) begin
            #62.5 bit_clk = 1'b1;
            #62.5 bit_clk = 1'b0;
        end
    endtask

    // Sends nfr frames of one pair and two more positions to close the last slot.
    task automatic send(input logic [1:0] fmt, input int slot, input int nfr,
        input logic [23:0] l, input logic [23:0] r, input int wlen);
        int p;
        int idx;
        logic rgt;
        logic [23:0] w;
        for (int k = 0; k < nfr * 2 * slot + 2; k++) begin
            p = k % (2 * slot);
            rgt = (p >= slot);
            idx = p % slot;
            w = rgt ? r : l;
            if (fmt == 2'h0) channel_select_clock = ((p + 1) % (2 * slot)) >= slot;
            else channel_select_clock = !rgt;
            if (fmt == 2'h2 && idx >= slot - wlen) serial_data = w[slot - 1 - idx];
            else if (fmt != 2'h2 && idx < wlen) serial_data = w[23 - idx];
            else serial_data = !serial_data;  // Unused bits toggle, never a tidy zero.
            #62.5 bit_clk = 1'b1;
            #62.5 bit_clk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
/*
 * Self-checking bench of the serial audio port receiver.
 * Assumes the source model drives the link; FIFO depth is cut to two for overrun.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sap_pkg::*;

    // ------------------------------------------------------------------
    // Signals, clock, instances
    // ------------------------------------------------------------------
    localparam logic [23:0] LW = 24'hA5C3E1;
    localparam logic [23:0] RW = 24'h3C5A96;
    logic clk = 1'b0, reset = 1'b1, bit_clk, sel, sdata, software_mode = 1'b0;
    logic [1:0] format_sel = 2'h0;
    logic [4:0] word_length = 5'h18;
    logic ds_req = 1'b0, byp_req = 1'b0, sd_n = 1'b1, clip_pin = 1'b0;
    logic fault_req = 1'b0, ext_low = 1'b0, pair_ready = 1'b1;
    logic f_out, f_oe, spk_en, clip_en, fault_seen, double_speed, hpf_enable;
    logic frame_error, overrun, pair_valid;
    logic [23:0] left_word, right_word;
    logic [47:0] q [$];
    int n_errors = 0, total_checks = 0, cycles = 0;
    wire logic fault_line = !(f_oe | ext_low);  // Open drain with pull-up.

    // The system clock runs free at 25 MHz.
    initial forever #20 clk = !clk;

    audio_source audio_source_i (.bit_clk(bit_clk), .channel_select_clock(sel),
        .serial_data(sdata));
    serial_audio_port_receiver #(.DEPTH(2)) serial_audio_port_receiver_i (.clk(clk),
        .reset(reset), .bit_clk(bit_clk), .channel_select_clock(sel), .serial_data(sdata),
        .software_mode(software_mode), .format_sel(format_sel), .word_length(word_length),
        .double_speed_req(ds_req), .hpf_bypass_req(byp_req), .speaker_shutdown_pin_n(sd_n),
        .soft_clip_pin(clip_pin), .fault_request(fault_req), .speaker_fault_pin_in(fault_line),
        .speaker_fault_pin_out(f_out), .speaker_fault_pin_oe(f_oe), .speaker_enable(spk_en),
        .soft_clip_enable(clip_en), .fault_seen(fault_seen), .double_speed(double_speed),
        .hpf_enable(hpf_enable), .frame_error(frame_error), .overrun(overrun),
        .pair_valid(pair_valid), .pair_ready(pair_ready), .left_word(left_word),
        .right_word(right_word));

    // Pops are logged just after the falling edge, when both sides stand settled.
    always @(negedge clk) begin
        #1;
        cycles++;
        if (pair_valid === 1'b1 && pair_ready === 1'b1) q.push_back({left_word, right_word});
        if (cycles == 40000) begin
            n_errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Reset is held while the link clock makes four periods, longer than six clocks.
    task automatic do_reset();
        @(negedge clk);
        reset = 1'b1;
        audio_source_i.idle(4);
        @(negedge clk);
        check(hpf_enable, 1'b1);
        check({pair_valid, overrun, frame_error, f_oe}, 4'h0);
        reset = 1'b0;
        q.delete();
    endtask

    // Sends three frames and compares the last pair with the masked words.
    task automatic pair(input logic [1:0] f, input int s, input int w, input logic [23:0] m);
        audio_source_i.send(f, s, 3, LW, RW, w);
        repeat (10) @(negedge clk);
        check(q.size() != 0, 1'b1);
        check(q[$], {LW & m, RW & m});
        check(frame_error, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_pin_i2s();
        int s;
        software_mode = 1'b0;
        format_sel = FMT_LJ;  // Must be ignored in pin mode.
        word_length = 5'h10;
        ds_req = 1'b1;
        byp_req = 1'b1;
        for (int i = 0; i < 3; i++) begin
            s = 16 + 8 * i;
            do_reset();
            pair(FMT_I2S, s, 24, ~(24'hFFFFFF >> (s > 24 ? 24 : s)));
        end
        check({double_speed, hpf_enable}, 2'h1);
        $display("test pin_i2s done");
    endtask

    task automatic t_formats();
        logic [1:0] f [4] = '{FMT_LJ, FMT_LJ, FMT_RJ, FMT_RJ};
        int s [4] = '{32, 24, 32, 24};
        int w [4] = '{16, 24, 24, 16};
        software_mode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            format_sel = f[i];
            word_length = w[i][4:0];
            do_reset();
            // leading or trailing zeros by format.
            if (f[i] == FMT_LJ) pair(f[i], s[i], w[i], ~(24'hFFFFFF >> w[i]));
            else pair(f[i], s[i], w[i], 24'hFFFFFF >> (24 - w[i]));
        end
        check({double_speed, hpf_enable}, 2'h2);
        $display("test formats done");
    endtask

    task automatic t_pins();
        sd_n = 1'b0;
        clip_pin = 1'b1;
        repeat (5) @(negedge clk);
        check({spk_en, clip_en}, 2'h1);
        sd_n = 1'b1;
        fault_req = 1'b1;
        @(negedge clk);
        check({f_oe, f_out}, 2'h2);
        repeat (4) @(negedge clk);
        check({spk_en, fault_seen}, 2'h3);
        fault_req = 1'b0;
        repeat (5) @(negedge clk);
        check({f_oe, fault_seen}, 2'h0);
        ext_low = 1'b1;
        repeat (5) @(negedge clk);
        check({f_oe, fault_seen}, 2'h1);
        ext_low = 1'b0;
        $display("test pins done");
    endtask

    task automatic t_overrun();
        software_mode = 1'b0;
        pair_ready = 1'b0;
        do_reset();
        audio_source_i.send(FMT_I2S, 32, 5, LW, RW, 24);
        repeat (10) @(negedge clk);
        check({overrun, pair_valid}, 2'h3);
        pair_ready = 1'b1;
        repeat (5) @(negedge clk);
        check(q.size(), 2);
        check(q[0], {LW, RW});
        check(pair_valid, 1'b0);
        $display("test overrun done");
    endtask

    task automatic t_frame_error();
        do_reset();
        audio_source_i.send(FMT_I2S, 20, 3, LW, RW, 24);
        repeat (10) @(negedge clk);
        check(frame_error, 1'b1);
        $display("test frame_error done");
    endtask

    // ------------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        t_pin_i2s();
        t_formats();
        t_pins();
        t_overrun();
        t_frame_error();
        print_verdict();
    end
endmodule
`default_nettype wire
